// ---- hw/adcf_pkg.sv ----
package adcf_pkg;

	// Register byte offsets on the Avalon-MM slave
	localparam logic [4:0] OFS_CTRL    = 5'h00;
	localparam logic [4:0] OFS_CFG     = 5'h04;
	localparam logic [4:0] OFS_RES_HI  = 5'h08;
	localparam logic [4:0] OFS_RES_LO  = 5'h0c;
	localparam logic [4:0] OFS_STATUS  = 5'h10;

	// Field positions
	localparam int CTRL_ENABLE_BIT   = 0;
	localparam int CTRL_GO_BIT       = 1;
	localparam int CTRL_CHAN_LSB     = 2;
	localparam int CFG_JUSTIFY_BIT   = 7;
	localparam int STATUS_DONE_BIT   = 0;

	// Reset values of control state
	localparam logic       ENABLE_RST  = 1'b0;
	localparam logic       GO_RST      = 1'b0;
	localparam logic [4:0] CHAN_RST    = 5'h00;
	localparam logic       JUSTIFY_RST = 1'b0;
	localparam logic       DONE_RST    = 1'b0;

	// Converter geometry and timing
	localparam int RES_BITS    = 10;
	localparam int UNUSED_BITS = 6;
	localparam int CLK_PERIOD_NS = 4;
	localparam int BIT_TIME_NS   = 16;
	localparam int BIT_CYCLES    =
		(BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [0:0] {
		SAR_IDLE    = 1'b0,
		SAR_CONVERT = 1'b1
	} adcf_sar_state_type;

endpackage : adcf_pkg

// ---- hw/adcf_justify.sv ----
`timescale 1ns/1ps
module adcf_justify (
	// Raw result and format
	input  wire logic [9:0] i_result,
	input  wire logic       i_right,
	// Register images
	output logic      [7:0] o_high,
	output logic      [7:0] o_low
);

	always_comb begin
		if (i_right) begin
			o_high = {6'h00, i_result[9:8]};
			o_low  = i_result[7:0];
		end else begin
			o_high = i_result[9:2];
			o_low  = {i_result[1:0], 6'h00};
		end
	end

endmodule : adcf_justify

// ---- hw/adcf_sar.sv ----
`timescale 1ns/1ps
module adcf_sar (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rstn,
	// Sequencing
	input  wire logic       i_start,
	input  wire logic       i_abort,
	// Analog core
	input  wire logic       i_cmp,
	output logic      [9:0] o_trial,
	// Result
	output logic            o_busy,
	output logic            o_complete,
	output logic            o_load,
	output logic      [9:0] o_result
);

	adcf_pkg::adcf_sar_state_type state_q, state_d;
	logic [9:0] sar_q, sar_d;
	logic [3:0] idx_q, idx_d;
	logic [7:0] cnt_q, cnt_d;
	logic       step_end;
	logic       fill;

	assign step_end   = (cnt_q == 8'(adcf_pkg::BIT_CYCLES - 1));
	assign o_busy     = (state_q == adcf_pkg::SAR_CONVERT);
	assign o_complete = o_busy && step_end && (idx_q == 4'h0);
	assign o_load     = o_complete || (o_busy && i_abort);
	assign o_trial    = sar_q;

	// An abort leaves undecided bits copying the last decided one
	always_comb begin
		fill = (idx_q == 4'h9) ? 1'b0 : sar_q[idx_q + 4'h1];
		o_result = sar_q;
		for (int b = 0; b < adcf_pkg::RES_BITS; b++) begin
			if (o_complete && b == 0) begin
				o_result[b] = i_cmp;
			end else if (!o_complete && b <= int'(idx_q)) begin
				o_result[b] = fill;
			end
		end
	end

	always_comb begin
		state_d = state_q;
		sar_d   = sar_q;
		idx_d   = idx_q;
		cnt_d   = cnt_q;
		case (state_q)
			adcf_pkg::SAR_IDLE: begin
				if (i_start) begin
					state_d = adcf_pkg::SAR_CONVERT;
					sar_d   = 10'h200;
					idx_d   = 4'h9;
					cnt_d   = 8'h00;
				end
			end
			adcf_pkg::SAR_CONVERT: begin
				if (i_abort || o_complete) begin
					state_d = adcf_pkg::SAR_IDLE;
				end else if (step_end) begin
					sar_d[idx_q]        = i_cmp;
					sar_d[idx_q - 4'h1] = 1'b1;
					idx_d = idx_q - 4'h1;
					cnt_d = 8'h00;
				end else begin
					cnt_d = cnt_q + 8'h01;
				end
			end
			default: begin
				state_d = adcf_pkg::SAR_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q <= adcf_pkg::SAR_IDLE;
			sar_q   <= 10'h000;
			idx_q   <= 4'h0;
			cnt_q   <= 8'h00;
		end else begin
			state_q <= state_d;
			sar_q   <= sar_d;
			idx_q   <= idx_d;
			cnt_q   <= cnt_d;
		end
	end

endmodule : adcf_sar

// ---- hw/adcf_top.sv ----
// How it works
// - Left format puts result bits 9..2 into the high register.
// - Left format puts bits 1..0 into low register bits 7..6.
// - Right format puts bits 9..8 into high register bits 1..0.
// - Right format puts bits 7..0 into the whole low register.
// - Result registers are read/write, unreset, and survive any reset.
// - Unused six bits of the result pair load as zero.
// - Completion clears go, sets the done flag, loads both results.
// - Clearing go early loads a partial result, filled with last bit.
// - The capture/compare special trigger sets go in hardware.
//
// Chosen here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
module adcf_top (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	// Avalon-MM slave
	input  wire logic  [4:0] i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic  [3:0] i_avs_byteenable,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	// Analog conversion core
	input  wire logic        i_cmp_out,
	output logic       [9:0] o_dac_code,
	output logic       [4:0] o_channel_select,
	output logic             o_adc_enable,
	output logic             o_converting,
	// Trigger and status
	input  wire logic        i_special_trigger,
	output logic             o_conversion_done_flag
);

	logic        ack_q, ack_d;
	logic [31:0] rdata_q, rdata_d;
	logic        enable_q, enable_d;
	logic        go_q, go_d;
	logic  [4:0] chan_q, chan_d;
	logic        justify_q, justify_d;
	logic        done_q, done_d;
	logic  [7:0] res_hi_q, res_hi_d;
	logic  [7:0] res_lo_q, res_lo_d;

	logic        wr_ok;
	logic        ctrl_wr;
	logic        busy;
	logic        complete;
	logic        load;
	logic        start;
	logic        abort;
	logic  [9:0] result;
	logic  [7:0] img_hi;
	logic  [7:0] img_lo;

	// One wait state per access keeps read data registered
	assign ack_d             = (i_avs_read || i_avs_write) && !ack_q;
	assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_q;
	assign o_avs_readdata    = rdata_q;
	assign wr_ok   = i_avs_write && ack_q && i_avs_byteenable[0];
	assign ctrl_wr = wr_ok && (i_avs_address == adcf_pkg::OFS_CTRL);

	assign o_channel_select       = chan_q;
	assign o_adc_enable           = enable_q;
	assign o_converting           = busy;
	assign o_conversion_done_flag = done_q;

	adcf_sar u_sar (
		.i_clk      (i_clk),
		.i_rstn     (i_rstn),
		.i_start    (start),
		.i_abort    (abort),
		.i_cmp      (i_cmp_out),
		.o_trial    (o_dac_code),
		.o_busy     (busy),
		.o_complete (complete),
		.o_load     (load),
		.o_result   (result)
	);

	adcf_justify u_justify (
		.i_result (result),
		.i_right  (justify_q),
		.o_high   (img_hi),
		.o_low    (img_lo)
	);

	// Control, status and go sequencing
	always_comb begin
		enable_d  = enable_q;
		chan_d    = chan_q;
		justify_d = justify_q;
		go_d      = go_q;
		done_d    = done_q;
		if (ctrl_wr) begin
			enable_d = i_avs_writedata[adcf_pkg::CTRL_ENABLE_BIT];
			chan_d   = i_avs_writedata[adcf_pkg::CTRL_CHAN_LSB +: 5];
			go_d     = i_avs_writedata[adcf_pkg::CTRL_GO_BIT] && enable_d;
		end
		if (wr_ok && i_avs_address == adcf_pkg::OFS_CFG) begin
			justify_d = i_avs_writedata[adcf_pkg::CFG_JUSTIFY_BIT];
		end
		if (wr_ok && i_avs_address == adcf_pkg::OFS_STATUS &&
				i_avs_writedata[adcf_pkg::STATUS_DONE_BIT]) begin
			done_d = 1'b0;
		end
		if (i_special_trigger && enable_d) begin
			go_d = 1'b1;
		end
		// Completion wins over a trigger in the same cycle
		if (complete) begin
			go_d   = 1'b0;
			done_d = 1'b1;
		end
	end

	assign start = go_d && !go_q;
	assign abort = busy && !go_d && !complete;

	// Result pair: a load outranks a software write in the same cycle
	always_comb begin
		res_hi_d = res_hi_q;
		res_lo_d = res_lo_q;
		if (wr_ok && i_avs_address == adcf_pkg::OFS_RES_HI) begin
			res_hi_d = i_avs_writedata[7:0];
		end
		if (wr_ok && i_avs_address == adcf_pkg::OFS_RES_LO) begin
			res_lo_d = i_avs_writedata[7:0];
		end
		if (load) begin
			res_hi_d = img_hi;
			res_lo_d = img_lo;
		end
	end

	always_comb begin
		rdata_d = 32'h0000_0000;
		case (i_avs_address)
			adcf_pkg::OFS_CTRL: begin
				rdata_d[adcf_pkg::CTRL_ENABLE_BIT]   = enable_q;
				rdata_d[adcf_pkg::CTRL_GO_BIT]       = go_q;
				rdata_d[adcf_pkg::CTRL_CHAN_LSB +: 5] = chan_q;
			end
			adcf_pkg::OFS_CFG: begin
				rdata_d[adcf_pkg::CFG_JUSTIFY_BIT] = justify_q;
			end
			adcf_pkg::OFS_RES_HI: begin
				rdata_d[7:0] = res_hi_q;
			end
			adcf_pkg::OFS_RES_LO: begin
				rdata_d[7:0] = res_lo_q;
			end
			adcf_pkg::OFS_STATUS: begin
				rdata_d[adcf_pkg::STATUS_DONE_BIT] = done_q;
			end
			default: begin
				rdata_d = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ack_q     <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			enable_q  <= adcf_pkg::ENABLE_RST;
			go_q      <= adcf_pkg::GO_RST;
			chan_q    <= adcf_pkg::CHAN_RST;
			justify_q <= adcf_pkg::JUSTIFY_RST;
			done_q    <= adcf_pkg::DONE_RST;
		end else begin
			ack_q     <= ack_d;
			rdata_q   <= ack_d ? rdata_d : rdata_q;
			enable_q  <= enable_d;
			go_q      <= go_d;
			chan_q    <= chan_d;
			justify_q <= justify_d;
			done_q    <= done_d;
		end
	end

	// No reset: contents are unknown at power-up and kept across resets
	always_ff @(posedge i_clk) begin
		res_hi_q <= res_hi_d;
		res_lo_q <= res_lo_d;
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);

	sequence s_left_load;
		load && !justify_q;
	endsequence

	sequence s_right_load;
		load && justify_q;
	endsequence

	sequence s_abort_req;
		busy && ctrl_wr && !i_avs_writedata[adcf_pkg::CTRL_GO_BIT]
		&& !complete && !i_special_trigger;
	endsequence

	a_left_high_bits: assert property (
		s_left_load |=> res_hi_q == $past(result[9:2]))
		else $error("left high byte wrong");

	a_left_low_bits: assert property (
		s_left_load |=> res_lo_q == {$past(result[1:0]), 6'h00})
		else $error("left low byte wrong");

	a_right_high_bits: assert property (
		s_right_load |=> res_hi_q == {6'h00, $past(result[9:8])})
		else $error("right high byte wrong");

	a_right_low_bits: assert property (
		s_right_load |=> res_lo_q == $past(result[7:0]))
		else $error("right low byte wrong");

	a_result_readback: assert property (
		i_avs_read && !ack_q && i_avs_address == adcf_pkg::OFS_RES_HI
		|=> o_avs_readdata[7:0] == $past(res_hi_q))
		else $error("high result readback wrong");

	a_done_clears_go: assert property (
		complete |=> !go_q && done_q && !busy)
		else $error("completion did not clear go or set flag");

	a_abort_partial: assert property (
		s_abort_req |-> load && !complete ##1 !busy && !go_q)
		else $error("early clear did not load partial result");

	a_trigger_sets_go: assert property (
		i_special_trigger && enable_q && !complete && !ctrl_wr |=> go_q)
		else $error("special trigger did not set go");

	a_write_holds: assert property (
		wr_ok && i_avs_address == adcf_pkg::OFS_RES_LO && !load
		##1 (!load && !wr_ok)[*2]
		|=> res_lo_q == $past(i_avs_writedata[7:0], 3))
		else $error("written low result not held");

	a_convert_bounded: assert property (
		start |=> busy ##[1:60] !busy)
		else $error("conversion did not end in time");

	a_right_pad_zero: assert property (
		s_right_load |=> res_hi_q[7:2] == 6'h00)
		else $error("right high pad bits not zero");

	a_left_pad_zero: assert property (
		s_left_load |=> res_lo_q[5:0] == 6'h00)
		else $error("left low pad bits not zero");

	// A load and a same-cycle write: the load is kept
	a_load_beats_write: assert property (
		load && wr_ok && i_avs_address == adcf_pkg::OFS_RES_HI
		|=> res_hi_q == $past(img_hi))
		else $error("software write beat a result load");

	a_sw_write_lands: assert property (
		wr_ok && i_avs_address == adcf_pkg::OFS_RES_HI && !load
		|=> res_hi_q == $past(i_avs_writedata[7:0]))
		else $error("high result write lost");

	a_low_write_lands: assert property (
		wr_ok && i_avs_address == adcf_pkg::OFS_RES_LO && !load
		|=> res_lo_q == $past(i_avs_writedata[7:0]))
		else $error("low result write lost");

	a_low_readback: assert property (
		i_avs_read && !ack_q && i_avs_address == adcf_pkg::OFS_RES_LO
		|=> o_avs_readdata[7:0] == $past(res_lo_q))
		else $error("low result readback wrong");

	a_one_wait: assert property (
		(i_avs_read || i_avs_write) && !ack_q |=> !o_avs_waitrequest)
		else $error("access took more than one wait state");

	a_abort_no_done: assert property (
		abort && !done_q |=> !done_q)
		else $error("early clear set the done flag");

	a_go_needs_enable: assert property (
		!enable_q && !ctrl_wr && !go_q |=> !go_q)
		else $error("go set while converter disabled");

	// Software polls go to see the end of a conversion
	a_go_tracks_busy: assert property (
		go_q == busy)
		else $error("go bit and conversion state disagree");

	a_done_clear: assert property (
		wr_ok && i_avs_address == adcf_pkg::OFS_STATUS &&
		i_avs_writedata[adcf_pkg::STATUS_DONE_BIT] && !complete
		|=> !done_q)
		else $error("done flag did not clear");

	a_load_while_busy: assert property (
		load |-> busy)
		else $error("result load outside a conversion");

endmodule : adcf_top

// ---- verif/adcf_core_model.sv ----
`timescale 1ns/1ps
module adcf_core_model (
	// Clock
	input  wire logic       i_clk,
	// Analog side
	input  wire logic [9:0] i_vin,
	input  wire logic [9:0] i_dac_code,
	input  wire logic       i_enable,
	output logic            o_cmp_out
);
	logic tgl_q = 1'b0;

	// A powered-down comparator gives no stable answer
	always_ff @(posedge i_clk) begin
		tgl_q <= !tgl_q;
	end
	assign o_cmp_out = i_enable ? (i_vin >= i_dac_code) : tgl_q;
endmodule : adcf_core_model

// ---- verif/tb_adc_result_formatter.sv ----
`timescale 1ns/1ps
module tb_adc_result_formatter;
	typedef struct packed {
		logic [9:0] vin;
		logic       rj;
		logic [7:0] hi;
		logic [7:0] lo;
	} adcf_row_type;
	localparam int         ACQ  = 8;
	localparam logic [4:0] CTL  = adcf_pkg::OFS_CTRL;
	localparam logic [4:0] CFG  = adcf_pkg::OFS_CFG;
	localparam logic [4:0] HI   = adcf_pkg::OFS_RES_HI;
	localparam logic [4:0] LO   = adcf_pkg::OFS_RES_LO;
	localparam logic [4:0] STAT = adcf_pkg::OFS_STATUS;
	localparam adcf_row_type ROWS [5] = '{
		'{10'h3ff, 1'b0, 8'hff, 8'hc0},
		'{10'h3ff, 1'b1, 8'h03, 8'hff},
		'{10'h155, 1'b0, 8'h55, 8'h40},
		'{10'h2aa, 1'b1, 8'h02, 8'haa},
		'{10'h000, 1'b0, 8'h00, 8'h00}
	};
	logic        clk, rstn, rd, wr, cmp, trig, wait_r, en, busy, done;
	logic  [4:0] addr, chan;
	logic  [3:0] be;
	logic [31:0] wdata, rdata;
	logic  [9:0] dac, vin;
	logic  [7:0] q;
	int          num_errors = 0;
	int          checked = 0;
	int          cycles = 0;

	adcf_top uut (
		.i_clk(clk), .i_rstn(rstn), .i_avs_address(addr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
		.i_avs_byteenable(be), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wait_r), .i_cmp_out(cmp), .o_dac_code(dac),
		.o_channel_select(chan), .o_adc_enable(en), .o_converting(busy),
		.i_special_trigger(trig), .o_conversion_done_flag(done)
	);
	adcf_core_model core (
		.i_clk(clk), .i_vin(vin), .i_dac_code(dac), .i_enable(en),
		.o_cmp_out(cmp)
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic test_done();
		$display("checked %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done

	// Sized for roughly nine times the expected run
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			test_done();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// Request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [4:0] a,
			input logic [7:0] d);
		@(posedge clk);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= {24'h0, d};
		do @(posedge clk); while (wait_r !== 1'b0);
		q = rdata[7:0];
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus

	task automatic rchk(input logic [4:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(q, e);
	endtask : rchk

	task automatic wait_done();
		for (int n = 0; n < 100 && done !== 1'b1; n++)
			@(negedge clk);
		chk({7'h0, done}, 8'h01);
		chk({7'h0, busy}, 8'h00);
	endtask : wait_done

	task automatic pulse_trig();
		@(posedge clk);
		trig <= 1'b1;
		@(posedge clk);
		trig <= 1'b0;
	endtask : pulse_trig

	initial begin
		rstn = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		addr = 5'h00;
		wdata = 32'h0;
		vin = 10'h000;
		trig = 1'b0;
		be = 4'hf;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rchk(CTL, 8'h00);
		rchk(CFG, 8'h00);
		rchk(STAT, 8'h00);
		$display("test reset done");
		foreach (ROWS[i]) begin
			vin <= ROWS[i].vin;
			bus(1'b1, CFG, {ROWS[i].rj, 7'h00});
			bus(1'b1, CTL, {1'b0, 5'(i), 2'b01});
			@(negedge clk);
			chk({3'h0, chan}, {3'h0, 5'(i)});
			repeat (ACQ) @(posedge clk);
			bus(1'b1, CTL, {1'b0, 5'(i), 2'b11});
			@(negedge clk);
			chk(dac[9:2], 8'h80);
			chk({6'h00, dac[1:0]}, 8'h00);
			chk({7'h0, busy}, 8'h01);
			wait_done();
			rchk(HI, ROWS[i].hi);
			rchk(LO, ROWS[i].lo);
			rchk(CTL, {1'b0, 5'(i), 2'b01});
			bus(1'b1, STAT, 8'h01);
			rchk(STAT, 8'h00);
			$display("test row %0d done", i);
		end
		// Abort part way: fill with the last decided bit
		vin <= 10'h2ff;
		bus(1'b1, CFG, 8'h80);
		bus(1'b1, CTL, 8'h01);
		repeat (ACQ) @(posedge clk);
		bus(1'b1, CTL, 8'h03);
		repeat (20) @(posedge clk);
		bus(1'b1, CTL, 8'h01);
		rchk(HI, 8'h02);
		rchk(LO, 8'hff);
		rchk(STAT, 8'h00);
		$display("test abort done");
		bus(1'b1, CTL, 8'h00);
		@(negedge clk);
		chk({7'h0, en}, 8'h00);
		pulse_trig();
		repeat (2) @(posedge clk);
		chk({7'h0, busy}, 8'h00);
		vin <= 10'h1c3;
		bus(1'b1, CFG, 8'h00);
		bus(1'b1, CTL, 8'h01);
		@(negedge clk);
		chk({7'h0, en}, 8'h01);
		repeat (ACQ) @(posedge clk);
		pulse_trig();
		wait_done();
		rchk(HI, 8'h70);
		rchk(LO, 8'hc0);
		rchk(CTL, 8'h01);
		$display("test trigger done");
		bus(1'b1, HI, 8'h5a);
		bus(1'b1, LO, 8'ha5);
		be <= 4'he;
		bus(1'b1, HI, 8'h33);
		be <= 4'hf;
		bus(1'b1, 5'h14, 8'hff);
		rchk(HI, 8'h5a);
		rchk(LO, 8'ha5);
		rchk(5'h14, 8'h00);
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rchk(HI, 8'h5a);
		rchk(LO, 8'ha5);
		rchk(CTL, 8'h00);
		$display("test hold done");
		test_done();
	end
endmodule : tb_adc_result_formatter
